// ---- rtl/pmrc_defines.svh ----
`ifndef PMRC_DEFINES_SVH
`define PMRC_DEFINES_SVH

// Register byte offsets on the plain register port.
`define PMRC_OFS_CTRL 8'h00
`define PMRC_OFS_STATUS 8'h04
`define PMRC_OFS_CFG 8'h10

// Control register field positions.
`define PMRC_CTRL_HARD 0
`define PMRC_CTRL_SOFT 1
`define PMRC_CTRL_STORE 2
`define PMRC_CTRL_FLEN 3
`define PMRC_CTRL_INSEL_LO 4

// Configuration word layout, stored image size and limits.
`define PMRC_NVM_WORDS 18
`define PMRC_CFG_CORE_IDX 5'h01
`define PMRC_CFG_OUT_IDX 5'h06
`define PMRC_LOOP_BW_MAX 4'h9
`define PMRC_FAST_BW_MAX 4'h5
`define PMRC_XPT_MAX 3'h4
`define PMRC_NVM_DEFAULT 32'h0000_0100
`define PMRC_INSEL_RESET 2'h0

// Timing: crystal edge watchdog.
`define PMRC_CLK_PERIOD_NS 100
`define PMRC_XTAL_TIMEOUT_NS 2000
`define PMRC_XTAL_TIMEOUT_CYC (`PMRC_XTAL_TIMEOUT_NS / `PMRC_CLK_PERIOD_NS)

`endif

// ---- rtl/pmrc_pkg.sv ----
package pmrc_pkg;

  // Operating modes; pmrc_init covers power-up and hard reset loading.
  typedef enum logic [2:0] {
    pmrc_init,
    pmrc_freerun,
    pmrc_acquire,
    pmrc_locked,
    pmrc_holdover
  } pmrc_mode_t;

  // Frequency plan and loop settings as applied to the synthesizer.
  typedef struct packed {
    logic fast_en;
    logic [3:0] fast_bw;
    logic [3:0] loop_bw;
    logic [4:0][15:0] core_div;
    logic [11:0][2:0] xpt;
    logic [11:0][7:0] rdiv;
  } pmrc_plan_t;

endpackage : pmrc_pkg

// ---- rtl/pmrc_sync.sv ----
`timescale 1ns/10ps
module pmrc_sync #(
  parameter int W = 1
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta;

  // Two flip-flop stages; the first is read only by the second.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule : pmrc_sync

// ---- rtl/pmrc_nvm.sv ----
`timescale 1ns/10ps
`include "pmrc_defines.svh"
module pmrc_nvm #(
  parameter int WORDS = `PMRC_NVM_WORDS
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic i_we,
  input wire logic [4:0] i_widx,
  input wire logic [31:0] i_wdata,
  output logic o_valid,
  output logic o_done,
  output logic [4:0] o_idx,
  output logic [31:0] o_data
);
  localparam logic [4:0] LAST = 5'(WORDS - 1);
  // Nonvolatile image; it keeps its contents through every reset.
  logic [31:0] mem [WORDS] = '{default: `PMRC_NVM_DEFAULT};
  logic busy;
  logic [4:0] cnt;

  if (WORDS < 1 || WORDS > 31) begin : g_bad_words
    $error("pmrc_nvm: WORDS out of range");
  end

  // Store port writes one word per cycle.
  always_ff @(posedge i_clock) begin
    if (i_we && i_widx <= LAST) begin
      mem[i_widx] <= i_wdata;
    end
  end

  // Download streams the whole image, one word per cycle; a new start restarts it.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      busy <= 1'b0;
      cnt <= 5'h00;
      o_valid <= 1'b0;
      o_done <= 1'b0;
      o_idx <= 5'h00;
      o_data <= 32'h0000_0000;
    end else begin
      o_valid <= busy && !i_start;
      o_done <= busy && !i_start && cnt == LAST;
      o_idx <= cnt;
      o_data <= mem[cnt];
      if (i_start) begin
        busy <= 1'b1;
        cnt <= 5'h00;
      end else if (busy) begin
        busy <= cnt != LAST;
        // The index parks on the last word so the image is never read out of range.
        if (cnt != LAST) begin
          cnt <= cnt + 5'h01;
        end
      end
    end
  end
endmodule : pmrc_nvm

// ---- rtl/pmrc_top.sv ----
// Behaviour
// - After init, exactly one of four modes.
// - Power-up loads configuration from nonvolatile store.
// - Register port unusable until init finishes.
// - Output clocks stay off until init completes.
// - Hard reset reloads everything like power-up.
// - Hard reset from pin or control bit.
// - Soft reset skips reload, applies written configuration.
// - After init, enter freerun with configured outputs.
// - Outputs freerun or follow one of four inputs.
// - Main loop bandwidth selectable, 0.1 to 100 Hz.
// - Fast bandwidth during acquisition, then main bandwidth.
// - Fast bandwidth selectable, 100 Hz to 4 kHz.
// - Register bit enables fast acquisition.
// - At most five core frequencies, crosspoint routed.
// - Per-output dividers over twelve outputs.
// - Frequency plan writable and storable in nonvolatile store.
// - Valid input starts acquisition, then locked.
// - On lock, lock pin high and status locked.
// - Holdover when no valid input remains after a lock; freerun if never locked.
// - Valid input during holdover restarts acquisition.
`timescale 1ns/10ps
`include "pmrc_defines.svh"
module pmrc_top
  import pmrc_pkg::*;
#(
  parameter int N_IN = 4,
  parameter int N_OUT = 12
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_hard_reset_pin_n,
  input wire logic [3:0] i_input_valid,
  input wire logic i_pll_locked,
  input wire logic i_crystal_oscillator,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output pmrc_mode_t o_mode,
  output logic o_init_done,
  output logic o_lock_loss_pin_n,
  output logic [11:0] o_out_enable,
  output logic [1:0] o_sel_input,
  output logic [3:0] o_loop_bw_active,
  output logic o_ref_tick,
  output pmrc_plan_t o_plan
);
  localparam logic [4:0] LAST_IDX = 5'(`PMRC_NVM_WORDS - 1);
  localparam logic [5:0] XTAL_LIMIT = 6'(`PMRC_XTAL_TIMEOUT_CYC);

  if (N_IN != 4 || N_OUT != 12) begin : g_bad_size
    $error("pmrc_top: only four inputs and twelve outputs are supported");
  end

  logic [6:0] sync_q;
  logic pin_n_s, locked_s, xtal_s, xtal_prev;
  logic [3:0] valid_s;
  logic boot, start, ctrl_hard, fast_en, soft_go, had_lock, xtal_alive;
  logic [1:0] in_sel, next_sel;
  logic [5:0] xtal_cnt;
  logic ld_valid, ld_done, st_busy;
  logic [4:0] ld_idx, st_idx;
  logic [31:0] ld_data;
  logic bus_ok, any_valid;
  pmrc_plan_t shadow;

  // Functions shared by download, register writes, reads and store.
  function automatic logic [31:0] cfg_get(input pmrc_plan_t p, input logic [4:0] idx);
    logic [4:0] k;
    k = idx - `PMRC_CFG_OUT_IDX;
    if (idx == 5'h00) begin
      cfg_get = {23'h0, p.fast_en, p.fast_bw, p.loop_bw};
    end else if (idx < `PMRC_CFG_OUT_IDX) begin
      cfg_get = {16'h0, p.core_div[idx - `PMRC_CFG_CORE_IDX]};
    end else if (idx <= LAST_IDX) begin
      cfg_get = {16'h0, p.rdiv[k], 5'h00, p.xpt[k]};
    end else begin
      cfg_get = 32'h0000_0000;
    end
  endfunction : cfg_get

  // Out-of-range codes saturate so the loop never sees an unsupported setting.
  function automatic pmrc_plan_t cfg_put(input pmrc_plan_t p, input logic [4:0] idx,
                                         input logic [31:0] d);
    logic [4:0] k;
    cfg_put = p;
    k = idx - `PMRC_CFG_OUT_IDX;
    if (idx == 5'h00) begin
      cfg_put.fast_en = d[8];
      cfg_put.fast_bw = (d[7:4] > `PMRC_FAST_BW_MAX) ? `PMRC_FAST_BW_MAX : d[7:4];
      cfg_put.loop_bw = (d[3:0] > `PMRC_LOOP_BW_MAX) ? `PMRC_LOOP_BW_MAX : d[3:0];
    end else if (idx < `PMRC_CFG_OUT_IDX) begin
      cfg_put.core_div[idx - `PMRC_CFG_CORE_IDX] = d[15:0];
    end else if (idx <= LAST_IDX) begin
      cfg_put.xpt[k] = (d[2:0] > `PMRC_XPT_MAX) ? `PMRC_XPT_MAX : d[2:0];
      cfg_put.rdiv[k] = d[15:8];
    end
  endfunction : cfg_put

  pmrc_sync #(.W(7)) u_sync (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_async({i_hard_reset_pin_n, i_pll_locked, i_crystal_oscillator, i_input_valid}),
    .o_sync(sync_q)
  );
  assign {pin_n_s, locked_s, xtal_s, valid_s} = sync_q;

  // A hard reset is the boot path again: pin low holds the restart.
  assign start = boot || !pin_n_s || ctrl_hard;
  assign bus_ok = o_init_done && !start;
  assign any_valid = |valid_s;

  pmrc_nvm #(.WORDS(`PMRC_NVM_WORDS)) u_nvm (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_start(start),
    .i_we(st_busy),
    .i_widx(st_idx),
    .i_wdata(cfg_get(o_plan, st_idx)),
    .o_valid(ld_valid),
    .o_done(ld_done),
    .o_idx(ld_idx),
    .o_data(ld_data)
  );

  // Control bits; hard and soft requests are one-shot.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      boot <= 1'b1;
      ctrl_hard <= 1'b0;
      soft_go <= 1'b0;
      in_sel <= `PMRC_INSEL_RESET;
    end else begin
      boot <= 1'b0;
      soft_go <= 1'b0;
      if (start) begin
        ctrl_hard <= 1'b0;
        in_sel <= `PMRC_INSEL_RESET;
      end else if (bus_ok && i_wr && i_addr == `PMRC_OFS_CTRL) begin
        ctrl_hard <= i_wdata[`PMRC_CTRL_HARD];
        soft_go <= i_wdata[`PMRC_CTRL_SOFT];
        in_sel <= i_wdata[`PMRC_CTRL_INSEL_LO +: 2];
      end
    end
  end

  // Store walks the applied plan into the nonvolatile image.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      st_busy <= 1'b0;
      st_idx <= 5'h00;
    end else if (start) begin
      st_busy <= 1'b0;
      st_idx <= 5'h00;
    end else if (st_busy) begin
      st_busy <= st_idx != LAST_IDX;
      st_idx <= st_idx + 5'h01;
    end else if (bus_ok && i_wr && i_addr == `PMRC_OFS_CTRL && i_wdata[`PMRC_CTRL_STORE]) begin
      st_busy <= 1'b1;
      st_idx <= 5'h00;
    end
  end

  // Pending plan: written by the host, refilled by every download.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      shadow <= '0;
    end else if (ld_valid) begin
      shadow <= cfg_put(shadow, ld_idx, ld_data);
    end else if (bus_ok && i_wr && i_addr >= `PMRC_OFS_CFG && i_addr[1:0] == 2'h0) begin
      shadow <= cfg_put(shadow, 5'((i_addr - `PMRC_OFS_CFG) >> 2), i_wdata);
    end
  end

  // Applied plan changes only on download or soft reset, never on a plain write.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_plan <= '0;
    end else if (ld_valid) begin
      o_plan <= cfg_put(o_plan, ld_idx, ld_data);
    end else if (soft_go) begin
      o_plan <= shadow;
    end
  end

  // Keep the chosen input while valid, else fall to the lowest valid one.
  always_comb begin
    next_sel = in_sel;
    if (!valid_s[in_sel]) begin
      for (int i = 3; i >= 0; i--) begin
        if (valid_s[i]) begin
          next_sel = 2'(i);
        end
      end
    end
  end

  // Mode sequencing.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mode <= pmrc_init;
      had_lock <= 1'b0;
    end else if (start) begin
      o_mode <= pmrc_init;
      had_lock <= 1'b0;
    end else begin
      unique case (o_mode)
        pmrc_init: if (ld_done) o_mode <= pmrc_freerun;
        pmrc_freerun: if (any_valid) o_mode <= pmrc_acquire;
        pmrc_acquire: begin
          if (!any_valid) begin
            o_mode <= had_lock ? pmrc_holdover : pmrc_freerun;
          end else if (locked_s) begin
            o_mode <= pmrc_locked;
            had_lock <= 1'b1;
          end
        end
        pmrc_locked: begin
          if (!any_valid) begin
            o_mode <= pmrc_holdover;
          end else if (!locked_s) begin
            o_mode <= pmrc_acquire;
          end
        end
        pmrc_holdover: if (any_valid) o_mode <= pmrc_acquire;
      endcase
    end
  end

  // Outputs seen by the synthesizer and the pins; all registered.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_init_done <= 1'b0;
      o_lock_loss_pin_n <= 1'b0;
      o_out_enable <= 12'h000;
      o_sel_input <= 2'h0;
      o_loop_bw_active <= 4'h0;
    end else begin
      o_init_done <= o_mode != pmrc_init && !start;
      o_lock_loss_pin_n <= o_mode == pmrc_locked && !start;
      o_out_enable <= {12{o_mode != pmrc_init && !start}};
      o_sel_input <= next_sel;
      o_loop_bw_active <= (o_mode == pmrc_acquire && o_plan.fast_en) ?
                          o_plan.fast_bw : o_plan.loop_bw;
    end
  end

  // Crystal watch: the 800 ns reference is sampled, so only edges matter.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      xtal_prev <= 1'b0;
      xtal_cnt <= 6'h00;
      xtal_alive <= 1'b0;
      o_ref_tick <= 1'b0;
    end else begin
      xtal_prev <= xtal_s;
      o_ref_tick <= xtal_s && !xtal_prev && o_init_done;
      if (xtal_s != xtal_prev) begin
        xtal_cnt <= 6'h00;
        xtal_alive <= 1'b1;
      end else if (xtal_cnt >= XTAL_LIMIT) begin
        xtal_alive <= 1'b0;
      end else begin
        xtal_cnt <= xtal_cnt + 6'h01;
      end
    end
  end

  // Read data stand one cycle after the strobe; zero while loading.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= 32'h0000_0000;
      if (i_rd && bus_ok) begin
        if (i_addr == `PMRC_OFS_CTRL) begin
          o_rdata <= {26'h0, in_sel, o_plan.fast_en, st_busy, 2'h0};
        end else if (i_addr == `PMRC_OFS_STATUS) begin
          o_rdata <= {24'h0, xtal_alive, had_lock, o_mode != pmrc_locked, o_sel_input,
                      o_mode};
        end else if (i_addr >= `PMRC_OFS_CFG && i_addr[1:0] == 2'h0) begin
          o_rdata <= cfg_get(shadow, 5'((i_addr - `PMRC_OFS_CFG) >> 2));
        end
      end
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  sequence hard_write_s;
    bus_ok && i_wr && i_addr == `PMRC_OFS_CTRL && i_wdata[`PMRC_CTRL_HARD];
  endsequence
  sequence soft_write_s;
    bus_ok && i_wr && i_addr == `PMRC_OFS_CTRL && i_wdata[`PMRC_CTRL_SOFT];
  endsequence

  mode_after_init_a: assert property (o_init_done |-> o_mode != pmrc_init)
    else $error("init done while still in init mode");
  outputs_quiet_a: assert property (o_mode == pmrc_init |=> o_out_enable == 12'h000)
    else $error("outputs enabled during init");
  bus_blocked_a: assert property (i_rd && !o_init_done |=> o_rdata == 32'h0)
    else $error("register read answered before init");
  freerun_entry_a: assert property (o_mode == pmrc_init && ld_done && !start
                                    |=> o_mode == pmrc_freerun)
    else $error("no freerun after download");
  hard_reload_a: assert property (hard_write_s |=> ##1 o_mode == pmrc_init && !ctrl_hard)
    else $error("hard reset bit did not start reload or clear");
  pin_reset_a: assert property (!pin_n_s |=> o_mode == pmrc_init ##1 !o_init_done)
    else $error("reset pin did not force init");
  soft_apply_a: assert property (soft_write_s ##1 !ld_valid |=> o_plan == $past(shadow))
    else $error("soft reset did not apply pending plan");
  acq_start_a: assert property (o_mode == pmrc_freerun && any_valid && !start
                                |=> o_mode == pmrc_acquire)
    else $error("valid input did not start acquisition");
  lock_pin_a: assert property (o_mode == pmrc_locked && !start |=> o_lock_loss_pin_n)
    else $error("lock pin low while locked");
  holdover_a: assert property (o_mode == pmrc_locked && !any_valid && !start
                               |=> o_mode == pmrc_holdover)
    else $error("holdover not entered");
  fast_bw_a: assert property (o_mode == pmrc_acquire && o_plan.fast_en
                              |=> o_loop_bw_active == $past(o_plan.fast_bw))
    else $error("fast bandwidth not applied in acquisition");
endmodule : pmrc_top

// ---- bench/pmrc_env_model.sv ----
`timescale 1ns/10ps
module pmrc_env_model
  import pmrc_pkg::*;
#(
  parameter int XTAL_HALF_NS = 400,
  parameter int LOCK_CYC = 12
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input pmrc_mode_t i_mode,
  input wire logic [3:0] i_input_valid,
  output logic o_crystal_oscillator,
  output logic o_pll_locked
);
  logic [7:0] acq_cnt;

  // The crystal runs free; the odd start offset keeps it out of phase with the clock.
  initial begin
    o_crystal_oscillator = 1'b0;
    #37;
    forever begin
      #(XTAL_HALF_NS) o_crystal_oscillator = ~o_crystal_oscillator;
    end
  end

  // The loop pulls in only while acquiring, and drops lock as soon as no input is valid.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      acq_cnt <= 8'h00;
      o_pll_locked <= 1'b0;
    end else if (i_input_valid == 4'h0) begin
      acq_cnt <= 8'h00;
      o_pll_locked <= 1'b0;
    end else if (i_mode == pmrc_acquire) begin
      if (acq_cnt == 8'(LOCK_CYC)) begin
        o_pll_locked <= 1'b1;
      end else begin
        acq_cnt <= acq_cnt + 8'h01;
      end
    end else if (i_mode != pmrc_locked) begin
      acq_cnt <= 8'h00;
      o_pll_locked <= 1'b0;
    end
  end
endmodule : pmrc_env_model

// ---- bench/pmrc_top_tb_top.sv ----
`timescale 1ns/10ps
`include "pmrc_defines.svh"
module pmrc_top_tb_top
  import pmrc_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_nrst;
  logic i_hard_reset_pin_n;
  logic [3:0] i_input_valid;
  logic [7:0] i_addr;
  logic [31:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic xtal;
  logic locked;
  logic [31:0] o_rdata;
  pmrc_mode_t o_mode;
  logic o_init_done;
  logic o_lock_loss_pin_n;
  logic [11:0] o_out_enable;
  logic [1:0] o_sel_input;
  logic [3:0] o_loop_bw_active;
  logic o_ref_tick;
  pmrc_plan_t o_plan;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  int ticks = 0;

  pmrc_top i_pmrc_top (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_hard_reset_pin_n(i_hard_reset_pin_n),
    .i_input_valid(i_input_valid),
    .i_pll_locked(locked),
    .i_crystal_oscillator(xtal),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_mode(o_mode),
    .o_init_done(o_init_done),
    .o_lock_loss_pin_n(o_lock_loss_pin_n),
    .o_out_enable(o_out_enable),
    .o_sel_input(o_sel_input),
    .o_loop_bw_active(o_loop_bw_active),
    .o_ref_tick(o_ref_tick),
    .o_plan(o_plan)
  );

  pmrc_env_model i_pmrc_env_model (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_mode(o_mode),
    .i_input_valid(i_input_valid),
    .o_crystal_oscillator(xtal),
    .o_pll_locked(locked)
  );

  // System clock at 10 MHz.
  always #50 i_clock = ~i_clock;

  task automatic end_of_test;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Write: one cycle of strobe beside address and data.
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    check(o_rdata, exp);
  endtask : rd_chk

  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : step

  // Bounded waits; a miss shows up as a mismatch of the awaited value.
  task automatic wait_mode(input pmrc_mode_t m);
    int n;
    n = 0;
    while (o_mode !== m && n < 60) begin
      step(1);
      n++;
    end
    check(32'(o_mode), 32'(m));
  endtask : wait_mode

  task automatic wait_init;
    int n;
    n = 0;
    while (o_init_done !== 1'b1 && n < 60) begin
      step(1);
      n++;
    end
    check(32'(o_init_done), 32'h1);
  endtask : wait_init

  task automatic set_valid(input logic [3:0] v);
    @(posedge i_clock);
    i_input_valid <= v;
  endtask : set_valid

  // A hang is cut short well beyond the expected length of the run.
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 4000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    i_nrst = 1'b0;
    i_hard_reset_pin_n = 1'b1;
    i_input_valid = 4'h0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    step(4);
    check(32'(o_mode), 32'(pmrc_init));
    check(32'(o_out_enable), 32'h0);
    @(posedge i_clock);
    i_nrst <= 1'b1;
    // An early access is refused while the image downloads.
    rd_chk(`PMRC_OFS_CFG, 32'h0);
    check(32'(o_out_enable), 32'h0);
    wait_init();
    check(32'(o_mode), 32'(pmrc_freerun));
    check(32'(o_out_enable), 32'h0000_0FFF);
    rd_chk(`PMRC_OFS_CFG, 32'h0000_0100);
    rd_chk(`PMRC_OFS_CFG + 8'h04, 32'h0000_0100);
    rd_chk(`PMRC_OFS_CFG + 8'h18, 32'h0000_0100);
    rd_chk(8'h08, 32'h0);
    rd_chk(`PMRC_OFS_STATUS, 32'h0000_00A1);
    // One tick per rising crystal edge, eight clock cycles apart.
    repeat (80) begin
      step(1);
      if (o_ref_tick === 1'b1) begin
        ticks++;
      end
    end
    check(32'(ticks >= 9 && ticks <= 11), 32'h1);
    // Codes beyond the top setting saturate; nothing applies before a soft reset.
    reg_wr(`PMRC_OFS_CFG, 32'h0000_01FF);
    rd_chk(`PMRC_OFS_CFG, 32'h0000_0159);
    check(32'(o_plan.loop_bw), 32'h0);
    reg_wr(`PMRC_OFS_CFG, 32'h0000_0123);
    reg_wr(`PMRC_OFS_CTRL, 32'h0000_0002);
    step(2);
    check(32'(o_plan.loop_bw), 32'h3);
    check(32'(o_plan.fast_bw), 32'h2);
    check(32'(o_plan.fast_en), 32'h1);
    rd_chk(`PMRC_OFS_CFG, 32'h0000_0123);
    // Acquire with the fast bandwidth, then lock on the main one.
    set_valid(4'h2);
    wait_mode(pmrc_acquire);
    step(1);
    check(32'(o_sel_input), 32'h1);
    check(32'(o_loop_bw_active), 32'h2);
    wait_mode(pmrc_locked);
    step(1);
    check(32'(o_lock_loss_pin_n), 32'h1);
    check(32'(o_loop_bw_active), 32'h3);
    rd_chk(`PMRC_OFS_STATUS, 32'h0000_00CB);
    set_valid(4'h0);
    wait_mode(pmrc_holdover);
    step(1);
    check(32'(o_lock_loss_pin_n), 32'h0);
    // With fast acquisition off, the main code applies while reacquiring.
    reg_wr(`PMRC_OFS_CFG, 32'h0000_0023);
    reg_wr(`PMRC_OFS_CTRL, 32'h0000_0002);
    set_valid(4'h4);
    wait_mode(pmrc_acquire);
    step(1);
    check(32'(o_sel_input), 32'h2);
    check(32'(o_loop_bw_active), 32'h3);
    wait_mode(pmrc_locked);
    set_valid(4'h0);
    reg_wr(`PMRC_OFS_CTRL, 32'h0000_0004);
    rd_chk(`PMRC_OFS_CTRL, 32'h0000_0004);
    step(25);
    rd_chk(`PMRC_OFS_CTRL, 32'h0);
    // An unapplied shadow edit must be lost when the bit reload runs.
    reg_wr(`PMRC_OFS_CFG, 32'h0000_0055);
    reg_wr(`PMRC_OFS_CTRL, 32'h0000_0031);
    step(4);
    check(32'(o_init_done), 32'h0);
    check(32'(o_out_enable), 32'h0);
    wait_init();
    step(30);
    check(32'(o_init_done), 32'h1);
    check(32'(o_mode), 32'(pmrc_freerun));
    rd_chk(`PMRC_OFS_CFG, 32'h0000_0023);
    rd_chk(`PMRC_OFS_CTRL, 32'h0);
    // The pin held low keeps the device in its loading state.
    @(posedge i_clock);
    i_hard_reset_pin_n <= 1'b0;
    step(30);
    check(32'(o_init_done), 32'h0);
    check(32'(o_out_enable), 32'h0);
    check(32'(o_mode), 32'(pmrc_init));
    @(posedge i_clock);
    i_hard_reset_pin_n <= 1'b1;
    wait_init();
    rd_chk(`PMRC_OFS_CFG, 32'h0000_0023);
    check(32'(o_plan.core_div[0]), 32'h0000_0100);
    check(32'(o_plan.rdiv[11]), 32'h0000_0001);
    // Device clock and reference pair share core divider 2; preferred input 2 beats input 0.
    reg_wr(`PMRC_OFS_CFG + 8'h18, 32'h0000_0202);
    reg_wr(`PMRC_OFS_CFG + 8'h1C, 32'h0000_4002);
    reg_wr(`PMRC_OFS_CTRL, 32'h0000_0022);
    set_valid(4'h5);
    step(4);
    check(32'(o_plan.xpt[0]), 32'h0000_0002);
    check(32'(o_plan.xpt[1]), 32'h0000_0002);
    check(32'(o_plan.rdiv[1]), 32'h0000_0040);
    check(32'(o_sel_input), 32'h0000_0002);
    rd_chk(`PMRC_OFS_CTRL, 32'h0000_0020);
    end_of_test();
  end
endmodule : pmrc_top_tb_top
